// [dv/vdm_alarm_bench.sv]
// self-checking bench of the distortion alarm block, registers over apb
// assumes the design package, the map header and the blocking model
`timescale 1ns/10ps
`include "vdm_map.svh"
module vdm_alarm_bench;
    import vdm_pkg::*;
    logic          pclk, presetn, psel, penable, pwrite, blk_req, pready, pslverr, block_in, err;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, time_ms, stamp, rd;
    vdm_ratio_type amp [3], pow [3], el1, el2, el3;
    vdm_sg_type    sg;
    logic          st, al, bl, disp, ev;
    logic [5:0]    flags;
    logic [2:0]    fault;
    int            n_fail, check_count, cyc;

    vdm_alarm #(.CYCLE_CLKS(18'h8)) i_vdm_alarm (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .amp_l1(amp[0]), .amp_l2(amp[1]), .amp_l3(amp[2]),
        .pow_l1(pow[0]), .pow_l2(pow[1]), .pow_l3(pow[2]),
        .block_in(block_in), .time_ms(time_ms), .setting_group(sg),
        .start_o(st), .alarm_o(al), .blocked_o(bl), .block_disp_o(disp), .evt_valid_o(ev),
        .evt_flags_o(flags), .evt_stamp_o(stamp), .evt_l1_o(el1), .evt_l2_o(el2),
        .evt_l3_o(el3), .evt_fault_o(fault));
    vdm_blk_matrix i_vdm_blk_matrix (
        .pclk(pclk), .presetn(presetn), .blk_req(blk_req), .block_in(block_in), .time_ms(time_ms));

    // 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("pready", 32'(pready), 32'h1);
        if (pready !== 1'b1)
            complete_run();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // waits for {blocked, alarm, start}; cyc counts the edges taken
    task automatic wait_out(input logic [2:0] want, input int lim);
        cyc = 0;
        while ({bl, al, st} !== want) begin
            @(posedge pclk);
            cyc++;
            if (cyc > lim) begin
                check("outputs", 32'({bl, al, st}), 32'(want));
                complete_run();
            end
        end
    endtask

    task automatic t_reset();
        apb(1'b0, `VDM_OFS_CTRL, 32'h0);
        check("ctrl", rd, 32'h312);
        apb(1'b0, `VDM_OFS_PICKUP, 32'h0);
        check("pickup", rd, 32'h3e8);
        apb(1'b0, `VDM_OFS_DELAY, 32'h0);
        check("delay", rd, 32'h7d0);
        apb(1'b1, 12'h0fc, 32'hffffffff);
        check("unmapped err", 32'(err), 32'h1);
        apb(1'b0, 12'h0fc, 32'h0);
        check("unmapped data", rd, 32'h0);
        // every behaviour code reads back
        for (int m = 1; m <= 5; m++) begin
            apb(1'b1, `VDM_OFS_CTRL, 32'h310 | 32'(m << 1));
            apb(1'b0, `VDM_OFS_STATUS, 32'h0);
            check("mode", 32'(rd[2:0]), 32'(m));
        end
        apb(1'b1, `VDM_OFS_CTRL, 32'h312);
        $display("test reset done");
    endtask

    task automatic t_alarm();
        apb(1'b1, `VDM_OFS_DELAY, 32'h3);
        sg <= 3'h5;
        amp[1] <= 16'h03e9;
        wait_out(3'b001, 40);
        check("start flags", 32'(flags), 32'h01);
        check("start event", 32'(ev), 32'h1);
        check("start l2", 32'(el2), 32'h3e9);
        check("start fault", 32'(fault), 32'h2);
        // block pulse between two ticks is ignored
        blk_req <= 1'b1;
        repeat (2) @(posedge pclk);
        blk_req <= 1'b0;
        wait_out(3'b011, 40);
        check("alarm delay", 32'(cyc), 32'd22);
        check("alarm flags", 32'(flags), 32'h04);
        apb(1'b0, `VDM_OFS_STATUS, 32'h0);
        check("cond", 32'(rd[5:4]), 32'(`VDM_COND_ALARM));
        apb(1'b0, `VDM_OFS_CNT_START, 32'h0);
        check("start count", rd, 32'h1);
        apb(1'b0, `VDM_OFS_REC_INFO, 32'h0);
        check("record info", 32'(rd[6:0]), 32'h52);
        apb(1'b0, `VDM_OFS_REC_L12, 32'h0);
        check("record l12", rd, 32'h03e90000);
        apb(1'b0, `VDM_OFS_REC_STAT, 32'h0);
        check("record fill", 32'(rd[11:8]), 32'h2);
        // record and event of one tick carry one stamp
        apb(1'b0, `VDM_OFS_REC_TIME, 32'h0);
        check("alarm stamp", rd, stamp);
        apb(1'b1, `VDM_OFS_REC_SEL, 32'h1);
        apb(1'b0, `VDM_OFS_REC_INFO, 32'h0);
        check("older record", 32'(rd[6:0]), 32'h50);
        apb(1'b1, `VDM_OFS_REC_SEL, 32'h0);
        // 970 is exactly 97 percent, still held
        amp[1] <= 16'h03ca;
        repeat (24) @(posedge pclk);
        check("hold at ratio", 32'({bl, al, st}), 32'h3);
        amp[1] <= 16'h03c9;
        wait_out(3'b000, 20);
        check("release flags", 32'(flags), 32'h0a);
        $display("test alarm done");
    endtask

    task automatic t_block();
        amp[2] <= 16'h07d0;
        wait_out(3'b001, 20);
        blk_req <= 1'b1;
        wait_out(3'b100, 20);
        check("display pulse", 32'(disp), 32'h1);
        check("block flags", 32'(flags), 32'h12);
        check("block l3", 32'(el3), 32'h7d0);
        check("block fault", 32'(fault), 32'h4);
        apb(1'b0, `VDM_OFS_CNT_BLOCK, 32'h0);
        check("block count", rd, 32'h1);
        // write-one clear of the counters, clear bit reads back 0
        apb(1'b1, `VDM_OFS_CTRL, 32'h712);
        apb(1'b0, `VDM_OFS_CNT_BLOCK, 32'h0);
        check("count clear", rd, 32'h0);
        apb(1'b0, `VDM_OFS_CTRL, 32'h0);
        check("clear bit", rd, 32'h312);
        blk_req <= 1'b0;
        amp[2] <= 16'h0;
        wait_out(3'b000, 20);
        $display("test block done");
    endtask

    task automatic t_force();
        // software block without forcing has no effect
        apb(1'b1, `VDM_OFS_CTRL, 32'h392);
        pow[0] <= 16'h1000;
        amp[0] <= 16'h1000;
        wait_out(3'b001, 20);
        amp[0] <= 16'h0;
        wait_out(3'b000, 20);
        apb(1'b1, `VDM_OFS_CTRL, 32'h3d2);
        amp[0] <= 16'h1000;
        wait_out(3'b100, 20);
        check("forced flags", 32'(flags), 32'h10);
        // power quantity picks up on pow alone
        apb(1'b1, `VDM_OFS_CTRL, 32'h322);
        amp[0] <= 16'h0;
        wait_out(3'b001, 20);
        apb(1'b1, `VDM_OFS_CTRL, 32'h323);
        repeat (24) @(posedge pclk);
        check("disabled", 32'({bl, al, st}), 32'h0);
        // mode 2 blocks on its own; only rising events kept
        apb(1'b1, `VDM_OFS_CTRL, 32'h114);
        amp[0] <= 16'h1000;
        wait_out(3'b100, 20);
        check("mode block flags", 32'(flags), 32'h10);
        check("block l1", 32'(el1), 32'h1000);
        amp[0] <= 16'h0;
        wait_out(3'b000, 20);
        check("off not kept", 32'(flags), 32'h10);
        check("off no event", 32'(ev), 32'h0);
        $display("test force done");
    endtask

    initial begin
        n_fail = 0;
        check_count = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, blk_req} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        amp = '{default: 16'h0};
        pow = '{default: 16'h0};
        sg = 3'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_alarm();
        t_block();
        t_force();
        complete_run();
    end
endmodule

// [dv/vdm_blk_matrix.sv]
// model of the blocking matrix and time stamp source beside the alarm block
// assumes the bench raises blk_req just after a rising pclk edge
`timescale 1ns/10ps
module vdm_blk_matrix #(
    parameter int MS_CLKS = 4  // clocks per stamp step, shortened
) (
    input  wire logic        pclk,     // system clock
    input  wire logic        presetn,  // async reset, low
    input  wire logic        blk_req,  // bench asks for blocking
    output      logic        block_in, // blocking level
    output      logic [31:0] time_ms   // running stamp
);
    int div;
    // blocking arrives early
    // one clock of lag, far below the 5 ms lead the source must keep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_in <= 1'b0;
            time_ms  <= 32'h0;
            div      <= 0;
        end else begin
            block_in <= blk_req;
            div      <= (div == MS_CLKS - 1) ? 0 : div + 1;
            time_ms  <= (div == MS_CLKS - 1) ? time_ms + 32'h1 : time_ms;
        end
    end
endmodule

// [logic/vdm_alarm.sv]
// voltage distortion monitor decision logic with APB registers
// assumes distortion values and time stamp arrive synchronous to pclk
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "vdm_map.svh"
module vdm_alarm #(
    parameter logic [17:0] CYCLE_CLKS = 18'(`VDM_CYCLE_CLKS)  // clocks per program cycle
) (
    input  wire logic                  pclk,          // 40 MHz clock
    input  wire logic                  presetn,       // async reset, low
    input  wire logic [11:0]           paddr,         // apb address
    input  wire logic                  psel,          // apb select
    input  wire logic                  penable,       // apb access phase
    input  wire logic                  pwrite,        // apb write
    input  wire logic [31:0]           pwdata,        // apb write data
    output      logic [31:0]           prdata,        // apb read data
    output      logic                  pready,        // apb ready
    output      logic                  pslverr,       // unmapped address
    input  wire vdm_pkg::vdm_ratio_type amp_l1,       // amplitude ratio l1
    input  wire vdm_pkg::vdm_ratio_type amp_l2,       // amplitude ratio l2
    input  wire vdm_pkg::vdm_ratio_type amp_l3,       // amplitude ratio l3
    input  wire vdm_pkg::vdm_ratio_type pow_l1,       // power ratio l1
    input  wire vdm_pkg::vdm_ratio_type pow_l2,       // power ratio l2
    input  wire vdm_pkg::vdm_ratio_type pow_l3,       // power ratio l3
    input  wire logic                  block_in,      // blocking matrix input
    input  wire logic [31:0]           time_ms,       // ms time stamp
    input  wire vdm_pkg::vdm_sg_type   setting_group, // active group
    output      logic                  start_o,       // start output
    output      logic                  alarm_o,       // alarm output
    output      logic                  blocked_o,     // blocked output
    output      logic                  block_disp_o,  // display event pulse
    output      logic                  evt_valid_o,   // event strobe
    output      logic [5:0]            evt_flags_o,   // event kinds
    output      logic [31:0]           evt_stamp_o,   // event time
    output      vdm_pkg::vdm_ratio_type evt_l1_o,     // value l1 at event
    output      vdm_pkg::vdm_ratio_type evt_l2_o,     // value l2 at event
    output      vdm_pkg::vdm_ratio_type evt_l3_o,     // value l3 at event
    output      logic [2:0]            evt_fault_o    // phases over threshold
);
    import vdm_pkg::*;

    typedef struct packed {
        logic [17:0] tick_cnt;
        logic [10:0] ctrl;
        logic [13:0] pickup;
        logic [18:0] delay;
        logic [18:0] tmr;
        logic        blk;
        logic        pick;
        logic        start;
        logic        alarm;
        logic        blocked;
        logic        disp;
        logic [15:0] cnt_st;
        logic [15:0] cnt_al;
        logic [15:0] cnt_bl;
        logic [3:0]  rec_sel;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        evt_valid;
        logic [5:0]  evt_flags;
        logic [31:0] stamp;
        vdm_ratio_type el1;
        vdm_ratio_type el2;
        vdm_ratio_type el3;
        logic [2:0]  efault;
    } vdm_state_type;

    vdm_state_type s_r;
    vdm_state_type s_nxt;

    vdm_ratio_type amp_v [3];
    vdm_ratio_type pow_v [3];
    vdm_ratio_type val   [3];
    logic [2:0]    over;
    logic [2:0]    below;
    logic          tick;
    logic [2:0]    mode;
    logic [1:0]    qty;
    logic          eff_blk;
    logic          active;
    logic          pick_n;
    logic          st_n;
    logic          al_n;
    logic          bl_n;
    logic [18:0]   tmr_n;
    logic [5:0]    ev_raw;
    logic [5:0]    ev_keep;
    logic [1:0]    evsel;
    logic [1:0]    cond;
    logic          wr_acc;
    logic          cnt_clr;
    logic          rec_wr;
    vdm_rec_type   rec_in;
    vdm_rec_type   rec_out;
    logic [3:0]    rec_ptr;
    logic [3:0]    rec_fill;
    logic [31:0]   rd_mux;
    logic          rd_err;

    assign amp_v = '{amp_l1, amp_l2, amp_l3};
    assign pow_v = '{pow_l1, pow_l2, pow_l3};
    assign mode  = s_r.ctrl[`VDM_CTRL_MODE_MSB:`VDM_CTRL_MODE_LSB];
    assign qty   = s_r.ctrl[`VDM_CTRL_QTY_MSB:`VDM_CTRL_QTY_LSB];
    assign evsel = s_r.ctrl[`VDM_CTRL_EVSEL_MSB:`VDM_CTRL_EVSEL_LSB];
    assign tick  = (s_r.tick_cnt == CYCLE_CLKS - 18'h1);

    // per phase quantity select and comparators
    // cross-multiplied so the 97 % level needs no divider
    for (genvar g = 0; g < 3; g++) begin : g_phase
        assign val[g]   = (qty == `VDM_QTY_POWER) ? pow_v[g] : amp_v[g];
        assign over[g]  = val[g] > 16'(s_r.pickup);
        assign below[g] = (23'(val[g]) * 23'(`VDM_RESET_DEN)) < (23'(s_r.pickup) * 23'(`VDM_RESET_NUM));
    end

    // condition code for the status register
    always_comb begin
        if (s_r.blocked)
            cond = `VDM_COND_BLOCKED;
        else if (s_r.alarm)
            cond = `VDM_COND_ALARM;
        else if (s_r.start)
            cond = `VDM_COND_START;
        else
            cond = `VDM_COND_NORMAL;
    end

    // decision path, evaluated once per program cycle
    always_comb begin
        eff_blk = (s_r.ctrl[`VDM_CTRL_FORCE] ? s_r.ctrl[`VDM_CTRL_SWBLK] : block_in)
                  | (mode == `VDM_MODE_BLOCKED) | (mode == `VDM_MODE_TESTBLK);
        active = !s_r.ctrl[`VDM_CTRL_ALM_DIS] && (mode != `VDM_MODE_OFF);
        if (!active)
            pick_n = 1'b0;
        else if (|over)
            pick_n = 1'b1;
        else if (&below)
            pick_n = 1'b0;
        else
            pick_n = s_r.pick;
        st_n = pick_n & !eff_blk;
        bl_n = pick_n & eff_blk;
        if (st_n && s_r.start)
            tmr_n = (s_r.tmr < s_r.delay) ? s_r.tmr + 19'h1 : s_r.tmr;
        else
            tmr_n = '0;
        al_n = st_n && (tmr_n >= s_r.delay);
        ev_raw = {s_r.blocked & !bl_n, bl_n & !s_r.blocked,
                  s_r.alarm & !al_n, al_n & !s_r.alarm,
                  s_r.start & !st_n, st_n & !s_r.start};
        ev_keep = ev_raw & {evsel[1], evsel[0], evsel[1], evsel[0], evsel[1], evsel[0]};
    end

    // ring record from rising outputs; lowest kind wins if several rise
    always_comb begin
        rec_wr = tick && (ev_raw[0] || ev_raw[2] || ev_raw[4]);
        rec_in.stamp = time_ms;
        rec_in.evt   = ev_raw[0] ? 3'h0 : (ev_raw[2] ? 3'h2 : 3'h4);
        rec_in.l1    = val[0];
        rec_in.l2    = val[1];
        rec_in.l3    = val[2];
        rec_in.sg    = setting_group;
    end

    // register read mux
    always_comb begin
        rd_err = 1'b0;
        case (paddr)
            `VDM_OFS_CTRL:      rd_mux = {21'h0, s_r.ctrl};
            `VDM_OFS_PICKUP:    rd_mux = {18'h0, s_r.pickup};
            `VDM_OFS_DELAY:     rd_mux = {13'h0, s_r.delay};
            `VDM_OFS_STATUS:    rd_mux = {21'h0, s_r.blocked, s_r.alarm, s_r.start, 2'h0, cond, 1'h0, mode};
            `VDM_OFS_CNT_START: rd_mux = {16'h0, s_r.cnt_st};
            `VDM_OFS_CNT_ALARM: rd_mux = {16'h0, s_r.cnt_al};
            `VDM_OFS_CNT_BLOCK: rd_mux = {16'h0, s_r.cnt_bl};
            `VDM_OFS_REC_STAT:  rd_mux = {20'h0, rec_fill, 4'h0, rec_ptr};
            `VDM_OFS_REC_SEL:   rd_mux = {28'h0, s_r.rec_sel};
            `VDM_OFS_REC_TIME:  rd_mux = rec_out.stamp;
            `VDM_OFS_REC_INFO:  rd_mux = {25'h0, rec_out.sg, 1'h0, rec_out.evt};
            `VDM_OFS_REC_L12:   rd_mux = {rec_out.l2, rec_out.l1};
            `VDM_OFS_REC_L3:    rd_mux = {16'h0, rec_out.l3};
            default: begin
                rd_mux = 32'h0;
                rd_err = 1'b1;
            end
        endcase
    end

    // next state of the whole block
    always_comb begin
        s_nxt = s_r;
        s_nxt.evt_valid = 1'b0;
        s_nxt.disp = 1'b0;
        s_nxt.tick_cnt = tick ? 18'h0 : s_r.tick_cnt + 18'h1;
        wr_acc = psel && penable && pwrite && s_r.pready;
        cnt_clr = wr_acc && (paddr == `VDM_OFS_CTRL) && pwdata[`VDM_CTRL_CNT_CLR];

        // apb: answer prepared in setup, ready in first access cycle
        s_nxt.pready = psel && !penable;
        if (psel && !penable) begin
            s_nxt.prdata = pwrite ? 32'h0 : rd_mux;
            s_nxt.pslverr = rd_err;
        end
        if (wr_acc && !s_r.pslverr) begin
            case (paddr)
                `VDM_OFS_CTRL:    s_nxt.ctrl = pwdata[10:0] & ~(11'h1 << `VDM_CTRL_CNT_CLR);
                `VDM_OFS_PICKUP:  s_nxt.pickup = pwdata[13:0];
                `VDM_OFS_DELAY:   s_nxt.delay = pwdata[18:0];
                `VDM_OFS_REC_SEL: s_nxt.rec_sel = pwdata[3:0];
                default: ;
            endcase
        end
        // clear first so a same-cycle increment still lands
        if (cnt_clr) begin
            s_nxt.cnt_st = '0;
            s_nxt.cnt_al = '0;
            s_nxt.cnt_bl = '0;
        end

        if (tick) begin
            s_nxt.blk = eff_blk;
            s_nxt.pick = pick_n;
            s_nxt.start = st_n;
            s_nxt.alarm = al_n;
            s_nxt.blocked = bl_n;
            s_nxt.tmr = tmr_n;
            s_nxt.disp = bl_n & !s_r.blocked;
            if (|ev_keep) begin
                s_nxt.evt_valid = 1'b1;
                s_nxt.evt_flags = ev_keep;
                s_nxt.stamp = time_ms;
                s_nxt.el1 = val[0];
                s_nxt.el2 = val[1];
                s_nxt.el3 = val[2];
                s_nxt.efault = over;
            end
            if (ev_raw[0])
                s_nxt.cnt_st = (cnt_clr ? 16'h0 : s_r.cnt_st) + 16'h1;
            if (ev_raw[2])
                s_nxt.cnt_al = (cnt_clr ? 16'h0 : s_r.cnt_al) + 16'h1;
            if (ev_raw[4])
                s_nxt.cnt_bl = (cnt_clr ? 16'h0 : s_r.cnt_bl) + 16'h1;
        end
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.ctrl <= `VDM_CTRL_RST;
            s_r.pickup <= `VDM_PICKUP_RST;
            s_r.delay <= 19'(`VDM_DELAY_RST);
        end else begin
            s_r <= s_nxt;
        end
    end

    vdm_record_ring i_vdm_record_ring (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (rec_wr),
        .wr_rec  (rec_in),
        .rd_idx  (s_r.rec_sel),
        .rd_rec  (rec_out),
        .wr_ptr  (rec_ptr),
        .fill    (rec_fill)
    );

    // outputs straight from the state register
    assign prdata       = s_r.prdata;
    assign pready       = s_r.pready;
    assign pslverr      = s_r.pslverr;
    assign start_o      = s_r.start;
    assign alarm_o      = s_r.alarm;
    assign blocked_o    = s_r.blocked;
    assign block_disp_o = s_r.disp;
    assign evt_valid_o  = s_r.evt_valid;
    assign evt_flags_o  = s_r.evt_flags;
    assign evt_stamp_o  = s_r.stamp;
    assign evt_l1_o     = s_r.el1;
    assign evt_l2_o     = s_r.el2;
    assign evt_l3_o     = s_r.el3;
    assign evt_fault_o  = s_r.efault;

    // checks on the decision path
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_blk_sample: assert property (!tick |=> $stable(s_r.blk))
        else $error("blocking sample moved between program cycles");
    chk_start_blocked: assert property (!(start_o && blocked_o))
        else $error("start and blocked asserted together");
    chk_start_drop: assert property ($rose(blocked_o) && $past(start_o) |-> !start_o && s_r.tmr == 19'h0)
        else $error("start or timer survived blocking");
    chk_disp_pulse: assert property ($rose(blocked_o) |-> block_disp_o ##1 !block_disp_o)
        else $error("display pulse missing on blocking");
    chk_alarm_start: assert property (alarm_o |-> start_o && !s_r.blk)
        else $error("alarm without start");
    chk_alarm_delay: assert property ($rose(alarm_o) |-> s_r.tmr == s_r.delay)
        else $error("alarm before delay elapsed");
    chk_disable_quiet: assert property (tick && s_r.ctrl[`VDM_CTRL_ALM_DIS] |=> !start_o && !blocked_o)
        else $error("outputs active while disabled");
    chk_evt_stamp: assert property (tick && |ev_keep |=> evt_valid_o && evt_stamp_o == $past(time_ms))
        else $error("event stamp wrong");
    chk_evt_select: assert property (evt_valid_o |-> (evt_flags_o & ~{3{evsel}}) == 6'h0)
        else $error("event kind not selected was emitted");
    chk_count_start: assert property (tick && ev_raw[0] && !cnt_clr |=> s_r.cnt_st == $past(s_r.cnt_st) + 16'h1)
        else $error("start counter missed an edge");
endmodule

// [logic/vdm_record_ring.sv]
// twelve-entry ring of operation records, newest read at index 0
// assumes writes come at most once per clock from the alarm logic
`timescale 1ns/10ps
`include "vdm_map.svh"
module vdm_record_ring (
    input  wire logic                pclk,     // system clock
    input  wire logic                presetn,  // async reset, low
    input  wire logic                wr_en,    // store one record
    input  wire vdm_pkg::vdm_rec_type wr_rec,  // record to store
    input  wire logic [3:0]          rd_idx,   // 0 newest
    output      vdm_pkg::vdm_rec_type rd_rec,  // selected record
    output      logic [3:0]          wr_ptr,   // next slot
    output      logic [3:0]          fill      // records held
);
    import vdm_pkg::*;

    typedef struct packed {
        vdm_rec_type [`VDM_REC_DEPTH-1:0] mem;
        logic [3:0]                       ptr;
        logic [3:0]                       cnt;
    } vdm_ring_type;

    vdm_ring_type s_r;
    vdm_ring_type s_nxt;
    logic [4:0]   pos;

    // oldest slot is overwritten first since ptr walks round
    always_comb begin
        s_nxt = s_r;
        if (wr_en) begin
            s_nxt.mem[s_r.ptr] = wr_rec;
            s_nxt.ptr = (s_r.ptr == 4'(`VDM_REC_DEPTH - 1)) ? 4'h0 : s_r.ptr + 4'h1;
            if (s_r.cnt != 4'(`VDM_REC_DEPTH))
                s_nxt.cnt = s_r.cnt + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // slot of the idx-th newest record; empty slots read zero
    always_comb begin
        pos = 5'(s_r.ptr) + 5'(`VDM_REC_DEPTH - 1) - 5'(rd_idx);
        if (pos >= 5'(`VDM_REC_DEPTH))
            pos = pos - 5'(`VDM_REC_DEPTH);
        rd_rec = (rd_idx < s_r.cnt) ? s_r.mem[pos[3:0]] : '0;
    end

    assign wr_ptr = s_r.ptr;
    assign fill   = s_r.cnt;
endmodule

// [shared/vdm_map.svh]
// constants of the voltage distortion monitor: timing, register map, fields
// assumes a 40 MHz pclk and APB byte addressing with one word per register
`ifndef VDM_MAP_SVH
`define VDM_MAP_SVH

// clock and program cycle timing
`define VDM_CLK_NS          25
`define VDM_PROG_CYCLE_NS   5000000
`define VDM_CYCLE_CLKS      (`VDM_PROG_CYCLE_NS / `VDM_CLK_NS)

// alarm delay: step and default in ms, default as a count of steps
`define VDM_DELAY_STEP_MS   5
`define VDM_DELAY_DFLT_MS   10000
`define VDM_DELAY_RST       (`VDM_DELAY_DFLT_MS / `VDM_DELAY_STEP_MS)

// pick-up threshold in 0.01 % units, reset ratio as a fraction
`define VDM_PICKUP_RST      14'h03e8
`define VDM_RESET_NUM       7'h61
`define VDM_RESET_DEN       7'h64
`define VDM_REC_DEPTH       12

// register byte offsets
`define VDM_OFS_CTRL        12'h000
`define VDM_OFS_PICKUP      12'h004
`define VDM_OFS_DELAY       12'h008
`define VDM_OFS_STATUS      12'h00c
`define VDM_OFS_CNT_START   12'h010
`define VDM_OFS_CNT_ALARM   12'h014
`define VDM_OFS_CNT_BLOCK   12'h018
`define VDM_OFS_REC_STAT    12'h01c
`define VDM_OFS_REC_SEL     12'h020
`define VDM_OFS_REC_TIME    12'h024
`define VDM_OFS_REC_INFO    12'h028
`define VDM_OFS_REC_L12     12'h02c
`define VDM_OFS_REC_L3      12'h030

// control register fields and reset value
`define VDM_CTRL_ALM_DIS    0
`define VDM_CTRL_MODE_LSB   1
`define VDM_CTRL_MODE_MSB   3
`define VDM_CTRL_QTY_LSB    4
`define VDM_CTRL_QTY_MSB    5
`define VDM_CTRL_FORCE      6
`define VDM_CTRL_SWBLK      7
`define VDM_CTRL_EVSEL_LSB  8
`define VDM_CTRL_EVSEL_MSB  9
`define VDM_CTRL_CNT_CLR    10
`define VDM_CTRL_RST        11'h312

// node behaviour, condition and quantity codes
`define VDM_MODE_ON         3'h1
`define VDM_MODE_BLOCKED    3'h2
`define VDM_MODE_TEST       3'h3
`define VDM_MODE_TESTBLK    3'h4
`define VDM_MODE_OFF        3'h5
`define VDM_COND_NORMAL     2'h0
`define VDM_COND_START      2'h1
`define VDM_COND_ALARM      2'h2
`define VDM_COND_BLOCKED    2'h3
`define VDM_QTY_POWER       2'h2

`endif

// [shared/vdm_pkg.sv]
// types shared by the voltage distortion monitor modules
// assumes nothing beyond a SystemVerilog compiler
package vdm_pkg;
    // distortion value in 0.01 % units
    typedef logic [15:0] vdm_ratio_type;
    typedef logic [2:0]  vdm_sg_type;
    // one operation record of the ring
    typedef struct packed {
        logic [31:0]   stamp;
        logic [2:0]    evt;
        vdm_ratio_type l1;
        vdm_ratio_type l2;
        vdm_ratio_type l3;
        vdm_sg_type    sg;
    } vdm_rec_type;
endpackage
